// *** core/scpr_pair_buf.sv ***
`timescale 1ns/100ps
`default_nettype none
// Two-entry buffer; head entry drives the output straight from flops
module scpr_pair_buf #(
  parameter int WIDTH = 9
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  logic [WIDTH-1:0] slot_ff [2]; // Entry 0 is the head
  logic [WIDTH-1:0] nxt_slot [2];
  logic [1:0] vld_ff; // Entry valid flags
  logic [1:0] nxt_vld;
  logic pop; // Head taken this cycle
  logic push; // Word accepted this cycle

  // Pop shifts the tail forward, then a push fills the first free entry
  always_comb begin
    pop = vld_ff[0] & out_ready;
    push = in_valid & ~vld_ff[1];
    nxt_slot = slot_ff;
    nxt_vld = vld_ff;
    if (pop) begin
      nxt_slot[0] = slot_ff[1];
      nxt_vld = {1'b0, vld_ff[1]};
    end
    if (push) begin
      if (!nxt_vld[0]) begin
        nxt_slot[0] = in_data;
        nxt_vld[0] = 1'b1;
      end else begin
        nxt_slot[1] = in_data;
        nxt_vld[1] = 1'b1;
      end
    end
  end

  // Register the entries
  always_ff @(posedge clock) begin
    if (rst) begin
      vld_ff <= 2'h0;
      slot_ff <= '{default: '0};
    end else begin
      vld_ff <= nxt_vld;
      slot_ff <= nxt_slot;
    end
  end

  assign in_ready = ~vld_ff[1]; // Full only when the tail entry is taken
  assign out_valid = vld_ff[0];
  assign out_data = slot_ff[0];

endmodule
`default_nettype wire

// *** core/scpr_pkg.sv ***
// Notes on behaviour
// - SPI samples input bit on clock rise
// - SPI output released when select rises
// - SPI releases request at second-last bit if empty
// - Released request stays high until next rise
// - More data: request low, host restarts read
// - Two-wire releases request at last bit if empty
// - Request line only pulled low, external pull-up
// - Two-wire read data changes after clock fall
package scpr_pkg;

  // Default 7-bit device address, arbitrary value
  localparam logic [6:0] SCPR_DEV_ADDR_DEF = 7'h1a;
  // Bit index (counted from 0) of the clock rise that decides the request line
  localparam logic [2:0] SCPR_SPI_DECIDE_BIT = 3'h6;
  localparam logic [2:0] SCPR_I2C_DECIDE_BIT = 3'h7;
  // Index of the last bit of a byte
  localparam logic [2:0] SCPR_LAST_BIT = 3'h7;
  // Byte shifted out when the read source is empty
  localparam logic [7:0] SCPR_IDLE_FILL = 8'hff;
  // Reset values
  localparam logic [2:0] SCPR_CNT_RST = 3'h0;
  localparam logic [7:0] SCPR_SH_RST = 8'h00;

  // Port sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,  // No transaction
    ST_ADDR,  // Shifting in address and direction
    ST_ACK,   // Device acknowledge slot (two-wire)
    ST_WR,    // Receiving write bytes
    ST_RD,    // Sending read bytes
    ST_MACK,  // Host acknowledge slot after a read byte (two-wire)
    ST_WAIT   // Not addressed or refused; wait for end
  } scpr_state_e;

  // Received byte with start-of-transaction marker
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } scpr_byte_s;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdin;
    logic sdio;
    logic two_wire;
  } scpr_pins_s;

  // Idle levels of the sampled pins
  localparam scpr_pins_s SCPR_PINS_RST = '{
    sclk: 1'b0, cs_n: 1'b1, sdin: 1'b0, sdio: 1'b1, two_wire: 1'b0
  };

endpackage

// *** core/scpr_port.sv ***
`timescale 1ns/100ps
`default_nettype none
// Serial control port, device end; four-wire or two-wire form chosen by pin
module scpr_port
  import scpr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = SCPR_DEV_ADDR_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic two_wire_mode,
  input wire logic ctl_serial_clk,
  input wire logic ctl_serial_cs_n,
  input wire logic ctl_serial_in,
  output logic ctl_serial_out,
  output logic ctl_serial_out_oe,
  input wire logic ctl_serial_bidir_in,
  output logic ctl_serial_bidir_out,
  output logic ctl_serial_bidir_oe,
  output logic host_attention_n_out,
  output logic host_attention_n_oe,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_ready,
  output logic rx_valid,
  output var scpr_byte_s rx_byte,
  input wire logic rx_ready,
  output logic rx_drop
);

  // Picks the byte to send; fill value when the source is empty
  function automatic logic [7:0] pick_byte(input logic v, input logic [7:0] d);
    return v ? d : SCPR_IDLE_FILL;
  endfunction

  scpr_pins_s pin_raw; // Pins as they arrive
  scpr_pins_s pin_meta_ff; // First synchroniser stage
  scpr_pins_s pin_sync_ff; // Second stage, safe to use
  scpr_pins_s pin_prev_ff; // Previous safe sample, for edges

  assign pin_raw = '{sclk: ctl_serial_clk, cs_n: ctl_serial_cs_n, sdin: ctl_serial_in,
                     sdio: ctl_serial_bidir_in, two_wire: two_wire_mode};

  // Two-flop synchroniser plus edge history
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_meta_ff <= SCPR_PINS_RST;
      pin_sync_ff <= SCPR_PINS_RST;
      pin_prev_ff <= SCPR_PINS_RST;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  logic tw; // Two-wire form selected
  logic rise; // Serial clock rising edge seen
  logic fall; // Serial clock falling edge seen
  logic start_c; // Two-wire start condition
  logic stop_c; // Two-wire stop condition
  logic din; // Data bit from the active input line
  logic [7:0] byte_in; // Shifter with the new bit appended
  logic decide; // Rise on which the request line is decided
  logic in_ready; // Receive buffer has room
  logic push; // Hand a received byte to the buffer
  scpr_byte_s push_byte; // Byte handed to the buffer
  logic [7:0] send_byte; // Next read byte, fill value when the source is empty

  assign tw = pin_sync_ff.two_wire;
  assign rise = pin_sync_ff.sclk & ~pin_prev_ff.sclk;
  assign fall = ~pin_sync_ff.sclk & pin_prev_ff.sclk;
  assign start_c = pin_sync_ff.sclk & pin_prev_ff.sclk & pin_prev_ff.sdio & ~pin_sync_ff.sdio;
  assign stop_c = pin_sync_ff.sclk & pin_prev_ff.sclk & ~pin_prev_ff.sdio & pin_sync_ff.sdio;
  assign din = tw ? pin_sync_ff.sdio : pin_sync_ff.sdin;
  assign send_byte = pick_byte(rd_valid, rd_data);

  scpr_state_e state_ff, nxt_state; // Sequencer state
  logic [2:0] cnt_ff, nxt_cnt; // Bit index within the byte
  logic [7:0] sh_ff, nxt_sh; // Shift register, MSB first
  logic dir_ff, nxt_dir; // Direction bit, 1 is read
  logic fresh_ff, nxt_fresh; // Byte just loaded; skip the next shift
  logic phase_ff, nxt_phase; // Second half of an acknowledge slot
  logic ack_ok_ff, nxt_ack_ok; // Device acknowledges the current slot
  logic first_ff, nxt_first; // Next received byte is the first one
  logic so_ff, nxt_so; // Four-wire output bit
  logic so_oe_ff, nxt_so_oe; // Four-wire output enable
  logic sda_oe_ff, nxt_sda_oe; // Two-wire line pulled low
  logic rd_ready_ff, nxt_rd_ready; // Read byte taken
  logic drop_ff, nxt_drop; // Write byte lost, buffer full

  assign byte_in = {sh_ff[6:0], din};
  assign decide = (state_ff == ST_RD) && rise
                  && (cnt_ff == (tw ? SCPR_I2C_DECIDE_BIT : SCPR_SPI_DECIDE_BIT));

  // Transaction sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_dir = dir_ff;
    nxt_fresh = fresh_ff;
    nxt_phase = phase_ff;
    nxt_ack_ok = ack_ok_ff;
    nxt_first = first_ff;
    nxt_so_oe = so_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_rd_ready = 1'b0;
    nxt_drop = 1'b0;
    push = 1'b0;
    push_byte = '{first: first_ff, data: byte_in};
    if (tw ? stop_c : pin_sync_ff.cs_n) begin
      // End of transaction: release both data output lines; request line left as is
      nxt_state = ST_IDLE;
      nxt_so_oe = 1'b0;
      nxt_sda_oe = 1'b0;
    end else if (tw ? start_c : (state_ff == ST_IDLE)) begin
      // New start (or select) always opens an address byte
      nxt_state = ST_ADDR;
      nxt_cnt = SCPR_CNT_RST;
      nxt_first = 1'b1;
      nxt_sda_oe = 1'b0;
      nxt_phase = 1'b0;
      nxt_fresh = 1'b0; // No skipped shift carried over from an older frame
    end else begin
      unique case (state_ff)
        ST_ADDR: if (rise) begin
          // Address then direction bit
          nxt_sh = byte_in;
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == SCPR_LAST_BIT) begin
            nxt_dir = byte_in[0];
            if (byte_in[7:1] != DEV_ADDR) begin
              nxt_state = ST_WAIT; // Another device is addressed
            end else if (tw) begin
              nxt_state = ST_ACK;
              nxt_ack_ok = 1'b1;
            end else if (byte_in[0]) begin
              // Four-wire read: first byte ready before the next rise
              nxt_state = ST_RD;
              nxt_sh = pick_byte(rd_valid, rd_data);
              nxt_rd_ready = rd_valid;
              nxt_fresh = 1'b1;
              nxt_so_oe = 1'b1;
            end else begin
              nxt_state = ST_WR;
            end
          end
        end
        ST_ACK: if (fall) begin
          if (!phase_ff) begin
            // Open the slot, pull low only when accepting
            nxt_phase = 1'b1;
            nxt_sda_oe = ack_ok_ff;
          end else begin
            nxt_phase = 1'b0;
            if (!ack_ok_ff) begin
              nxt_state = ST_WAIT;
              nxt_sda_oe = 1'b0;
            end else if (dir_ff) begin
              nxt_state = ST_RD;
              nxt_sh = pick_byte(rd_valid, rd_data);
              nxt_rd_ready = rd_valid;
              nxt_sda_oe = ~send_byte[7];
            end else begin
              nxt_state = ST_WR;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        ST_WR: if (rise) begin
          nxt_sh = byte_in;
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == SCPR_LAST_BIT) begin
            // Byte complete: stored, or refused when the buffer is full
            push = in_ready;
            nxt_drop = ~in_ready;
            nxt_first = 1'b0;
            if (tw) begin
              nxt_state = ST_ACK;
              nxt_ack_ok = in_ready;
            end
          end
        end
        ST_RD: begin
          if (rise) begin
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == SCPR_LAST_BIT) begin
              if (tw) begin
                nxt_state = ST_MACK;
              end else begin
                nxt_sh = pick_byte(rd_valid, rd_data);
                nxt_rd_ready = rd_valid;
                nxt_fresh = 1'b1;
              end
            end
          end else if (fall) begin
            // Next bit presented after the falling edge
            if (fresh_ff) begin
              nxt_fresh = 1'b0;
            end else begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_sda_oe = ~sh_ff[6];
            end
          end
        end
        ST_MACK: begin
          if (fall && !phase_ff) begin
            nxt_phase = 1'b1;
            nxt_sda_oe = 1'b0; // Host drives its acknowledge
          end else if (rise && din) begin
            nxt_state = ST_WAIT; // Host declined more data
            nxt_phase = 1'b0;
          end else if (fall) begin
            nxt_phase = 1'b0;
            nxt_state = ST_RD;
            nxt_sh = pick_byte(rd_valid, rd_data);
            nxt_rd_ready = rd_valid;
            nxt_sda_oe = ~send_byte[7];
          end
        end
        default: ;
      endcase
    end
    nxt_so = nxt_sh[7];
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= SCPR_CNT_RST;
      sh_ff <= SCPR_SH_RST;
      dir_ff <= 1'b0;
      fresh_ff <= 1'b0;
      phase_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      first_ff <= 1'b0;
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      rd_ready_ff <= 1'b0;
      drop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      dir_ff <= nxt_dir;
      fresh_ff <= nxt_fresh;
      phase_ff <= nxt_phase;
      ack_ok_ff <= nxt_ack_ok;
      first_ff <= nxt_first;
      so_ff <= nxt_so;
      so_oe_ff <= nxt_so_oe;
      sda_oe_ff <= nxt_sda_oe;
      rd_ready_ff <= nxt_rd_ready;
      drop_ff <= nxt_drop;
    end
  end

  logic attn_oe_ff, nxt_attn_oe; // Request line pulled low
  logic hold_ff, nxt_hold; // Released line held until next rise

  // Request line: pulled low while read data waits
  always_comb begin
    nxt_hold = hold_ff & ~rise;
    if (decide) begin
      nxt_attn_oe = rd_valid;
      nxt_hold = ~rd_valid;
    end else if (nxt_hold) begin
      nxt_attn_oe = 1'b0;
    end else if (state_ff == ST_RD
                 && cnt_ff < (tw ? SCPR_I2C_DECIDE_BIT : SCPR_SPI_DECIDE_BIT)) begin
      nxt_attn_oe = attn_oe_ff; // Held through the byte until decided
    end else begin
      nxt_attn_oe = rd_valid;
    end
  end

  // Request line registers
  always_ff @(posedge clock) begin
    if (rst) begin
      attn_oe_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      attn_oe_ff <= nxt_attn_oe;
      hold_ff <= nxt_hold;
    end
  end

  // Received bytes wait here; a byte arriving with both entries taken is dropped
  scpr_pair_buf #(
    .WIDTH($bits(scpr_byte_s))
  ) u_rx_buf (
    .clock(clock),
    .rst(rst),
    .in_valid(push),
    .in_data(push_byte),
    .in_ready(in_ready),
    .out_valid(rx_valid),
    .out_data(rx_byte),
    .out_ready(rx_ready)
  );

  assign ctl_serial_out = so_ff;
  assign ctl_serial_out_oe = so_oe_ff;
  assign ctl_serial_bidir_out = 1'b0; // Open drain: only ever low
  assign ctl_serial_bidir_oe = sda_oe_ff;
  assign host_attention_n_out = 1'b0; // Open drain: only ever low
  assign host_attention_n_oe = attn_oe_ff;
  assign rd_ready = rd_ready_ff;
  assign rx_drop = drop_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_spi_sample_in: assert property (
    (!tw && !pin_sync_ff.cs_n && state_ff inside {ST_ADDR, ST_WR} && nxt_state != ST_RD
     && rise)
      |=> sh_ff[0] == $past(pin_sync_ff.sdin))
    else $error("input bit not captured on clock rise");
  a_spi_out_release: assert property (
    (!tw && pin_sync_ff.cs_n) |=> !ctl_serial_out_oe)
    else $error("serial output still driven after select high");
  a_spi_attn_decide: assert property (
    (!tw && decide && !rd_valid) |=> !host_attention_n_oe ##1 !host_attention_n_oe)
    else $error("request not released at second-to-last bit");
  a_attn_hold_high: assert property (
    (hold_ff && !rise) |=> !host_attention_n_oe && hold_ff)
    else $error("request pulled low before next clock rise");
  a_attn_relow: assert property (
    (hold_ff && rise && !decide && rd_valid) |=> host_attention_n_oe)
    else $error("request not pulled low again with data waiting");
  a_i2c_attn_decide: assert property (
    (tw && decide && !rd_valid) |=> !host_attention_n_oe)
    else $error("request not released at last bit");
  a_attn_only_data: assert property (
    $rose(host_attention_n_oe) |-> $past(rd_valid))
    else $error("request pulled low with no data");
  a_i2c_change_fall: assert property (
    (tw && state_ff == ST_RD && $past(state_ff) == ST_RD && $changed(sda_oe_ff))
      |-> $past(fall))
    else $error("data line changed away from clock fall");

  c_spi_read: cover property (!tw && state_ff == ST_RD && rd_ready_ff);
  c_i2c_restart: cover property (tw && hold_ff ##[1:300] host_attention_n_oe);
  c_write_push: cover property (push && tw);
  c_write_drop: cover property (drop_ff);

endmodule
`default_nettype wire

// *** verification/scpr_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Host end of the control port: drives the serial clock, select and data
module scpr_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdin,
  output logic sda_low,
  input wire logic sdout,
  input wire logic sdout_oe,
  input wire logic sda,
  output int glitches
);
  // Half period of the 125 ns serial clock
  localparam realtime HALF = 62.5;

  // Idle levels; the serial clock stands still between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdin = 1'b0;
    sda_low = 1'b0;
    glitches = 0;
  end

  // Select a four-wire frame; a new frame after release restarts a read
  task automatic spi_open();
    cs_n = 1'b0;
    #HALF;
  endtask

  // End a four-wire frame; data line shows the inverse of its last value
  task automatic spi_close();
    #HALF;
    cs_n = 1'b1;
    sdin = ~sdin;
    #250;
  endtask

  // One byte MSB first; data set at the fall, device output taken at the rise
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdin = tx[i];
      #HALF;
      sclk = 1'b1;
      rx[i] = sdout_oe ? sdout : 1'bx;
      #HALF;
      sclk = 1'b0;
    end
  endtask

  // Two-wire bus at rest: clock high, line released to the pull-up
  task automatic i2c_idle();
    sclk = 1'b1;
    sda_low = 1'b0;
    #HALF;
  endtask

  // Start or repeated start: line falls while the clock is high
  task automatic i2c_start();
    sda_low = 1'b0;
    #HALF;
    sclk = 1'b1;
    #HALF;
    sda_low = 1'b1;
    #HALF;
    sclk = 1'b0;
  endtask

  // One bit slot; the line must not move while the clock is high
  task automatic i2c_bit(input logic b, output logic r);
    #20;
    sda_low = !b;
    #42.5;
    sclk = 1'b1;
    r = sda;
    #61.5;
    if (sda !== r) begin
      glitches++;
    end
    #1;
    sclk = 1'b0;
  endtask

  // Eight bits then the acknowledge slot, driven with hb by the host
  task automatic i2c_byte(input logic [7:0] tx, input logic hb, output logic [7:0] rx,
                          output logic ack);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(tx[i], rx[i]);
    end
    i2c_bit(hb, ack);
  endtask

  // Stop: line rises while the clock is high, then the bus rests
  task automatic i2c_stop();
    #20;
    sda_low = 1'b1;
    #42.5;
    sclk = 1'b1;
    #HALF;
    sda_low = 1'b0;
    #300;
  endtask
endmodule
`default_nettype wire

// *** verification/scpr_port_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
// Top bench: host model on the serial side, byte source and sink on the user side
module scpr_port_bench;
  import scpr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic two_wire_mode = 1'b0;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic rx_ready = 1'b0;
  logic rx_hold = 1'b1; // Stalls the receive side
  wire sclk, cs_n, sdin, host_low, sdo, sdo_oe, bd_out, bd_oe, at_out, at_oe;
  wire rd_ready, rx_valid, rx_drop;
  scpr_byte_s rx_byte;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int drops = 0;
  int glitches;
  logic [7:0] rd_q[$]; // Bytes offered for reading
  scpr_byte_s exp_rx[$]; // Expected received bytes
  // Open-drain lines with pull-ups
  wire sda = ((bd_oe && !bd_out) || host_low) ? 1'b0 : 1'b1;
  wire attn = (at_oe && !at_out) ? 1'b0 : 1'b1;

  always #5 clock = ~clock;

  scpr_port i_scpr_port (.clock(clock), .rst(rst), .two_wire_mode(two_wire_mode),
    .ctl_serial_clk(sclk), .ctl_serial_cs_n(cs_n), .ctl_serial_in(sdin),
    .ctl_serial_out(sdo), .ctl_serial_out_oe(sdo_oe), .ctl_serial_bidir_in(sda),
    .ctl_serial_bidir_out(bd_out), .ctl_serial_bidir_oe(bd_oe),
    .host_attention_n_out(at_out), .host_attention_n_oe(at_oe), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ready(rd_ready), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .rx_drop(rx_drop));

  scpr_host_model i_scpr_host_model (.sclk(sclk), .cs_n(cs_n), .sdin(sdin),
    .sda_low(host_low), .sdout(sdo), .sdout_oe(sdo_oe), .sda(sda), .glitches(glitches));

  // Compare tasks, one per kind of result
  task automatic check_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: read byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_rx(input scpr_byte_s got, input scpr_byte_s exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: received %h expected %h", $time, got, exp);
    end
  endtask

  // Report counts and verdict, then stop
  task automatic finish_test();
    $display("Comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Wait a bounded time for the receive queue to empty
  task automatic wait_drain();
    for (int i = 0; i < 300 && exp_rx.size() > 0; i++) begin
      @(posedge clock);
    end
    check_bit(exp_rx.size() == 0, 1'b1, "bytes not delivered");
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      $display("ERROR %0t: timeout", $time);
      finish_test();
    end
  end

  // Read source and randomly stalling sink; empty source shows random data
  always @(posedge clock) begin
    if (rd_ready === 1'b1 && rd_valid && rd_q.size() > 0) begin
      void'(rd_q.pop_front());
    end
    rd_valid <= rd_q.size() > 0;
    rd_data <= (rd_q.size() > 0) ? rd_q[0] : 8'($urandom);
    rx_ready <= !rx_hold && ($urandom_range(0, 3) != 0);
    if (rx_drop === 1'b1) begin
      drops++;
    end
  end

  // Output watcher: each delivered byte against the oldest note
  always @(posedge clock) begin
    if (!rst && rx_valid === 1'b1 && rx_ready) begin
      if (exp_rx.size() == 0) begin
        check_bit(1'b1, 1'b0, "unexpected byte");
      end else begin
        check_rx(rx_byte, exp_rx.pop_front());
      end
    end
  end

  // Main sequence
  initial begin
    logic [7:0] b;
    logic [7:0] r;
    logic [7:0] v[3];
    logic ack;
    void'($urandom(32'h98c4));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check_bit(at_out, 1'b0, "request drives high");
    // Four-wire write into a stalled receiver: third byte finds it full
    i_scpr_host_model.spi_open();
    i_scpr_host_model.spi_byte({SCPR_DEV_ADDR_DEF, 1'b0}, r);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      if (i < 2) exp_rx.push_back(scpr_byte_s'{first: (i == 0), data: b});
      i_scpr_host_model.spi_byte(b, r);
    end
    i_scpr_host_model.spi_close();
    check_bit(drops == 1, 1'b1, "drop count");
    @(negedge clock) rx_hold = 1'b0;
    wait_drain();
    // Another address is ignored
    i_scpr_host_model.spi_open();
    i_scpr_host_model.spi_byte({~SCPR_DEV_ADDR_DEF, 1'b0}, r);
    i_scpr_host_model.spi_byte(8'($urandom), r);
    i_scpr_host_model.spi_close();
    // Four-wire read of two bytes, then restart for a late byte
    for (int i = 0; i < 3; i++) v[i] = 8'($urandom);
    @(negedge clock);
    rd_q.push_back(v[0]);
    rd_q.push_back(v[1]);
    i_scpr_host_model.spi_open();
    i_scpr_host_model.spi_byte({SCPR_DEV_ADDR_DEF, 1'b1}, r);
    i_scpr_host_model.spi_byte(8'($urandom), r);
    check_byte(r, v[0]);
    check_bit(attn, 1'b0, "request with data left");
    i_scpr_host_model.spi_byte(8'($urandom), r);
    check_byte(r, v[1]);
    check_bit(attn, 1'b1, "request when empty");
    @(negedge clock) rd_q.push_back(v[2]);
    #200;
    check_bit(attn, 1'b1, "request held until rise");
    i_scpr_host_model.spi_close();
    check_bit(sdo_oe, 1'b0, "output released");
    i_scpr_host_model.spi_open();
    i_scpr_host_model.spi_byte({SCPR_DEV_ADDR_DEF, 1'b1}, r);
    check_bit(attn, 1'b0, "request for new data");
    i_scpr_host_model.spi_byte(8'($urandom), r);
    check_byte(r, v[2]);
    i_scpr_host_model.spi_close();
    // Two-wire form
    i_scpr_host_model.i2c_idle();
    @(posedge clock) two_wire_mode <= 1'b1;
    repeat (6) @(posedge clock);
    i_scpr_host_model.i2c_start();
    i_scpr_host_model.i2c_byte({SCPR_DEV_ADDR_DEF, 1'b0}, 1'b1, r, ack);
    check_bit(ack, 1'b0, "address ack");
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      exp_rx.push_back(scpr_byte_s'{first: (i == 0), data: b});
      i_scpr_host_model.i2c_byte(b, 1'b1, r, ack);
      check_bit(ack, 1'b0, "write ack");
    end
    i_scpr_host_model.i2c_stop();
    i_scpr_host_model.i2c_start();
    i_scpr_host_model.i2c_byte({~SCPR_DEV_ADDR_DEF, 1'b0}, 1'b1, r, ack);
    check_bit(ack, 1'b1, "foreign address ack");
    i_scpr_host_model.i2c_stop();
    // Two-wire read of one byte, then new start for a late byte
    @(negedge clock) rd_q.push_back(v[1]);
    i_scpr_host_model.i2c_start();
    i_scpr_host_model.i2c_byte({SCPR_DEV_ADDR_DEF, 1'b1}, 1'b1, r, ack);
    i_scpr_host_model.i2c_byte(8'hff, 1'b1, r, ack);
    check_byte(r, v[1]);
    check_bit(attn, 1'b1, "two-wire request when empty");
    @(negedge clock) rd_q.push_back(v[0]);
    #200;
    check_bit(attn, 1'b0, "two-wire request low again");
    i_scpr_host_model.i2c_stop();
    i_scpr_host_model.i2c_start();
    i_scpr_host_model.i2c_byte({SCPR_DEV_ADDR_DEF, 1'b1}, 1'b1, r, ack);
    check_bit(attn, 1'b0, "two-wire request for new data");
    i_scpr_host_model.i2c_byte(8'hff, 1'b1, r, ack);
    check_byte(r, v[0]);
    i_scpr_host_model.i2c_stop();
    check_bit(glitches == 0, 1'b1, "line moved while clock high");
    check_bit(bd_out, 1'b0, "shared line drives high");
    wait_drain();
    finish_test();
  end
endmodule
`default_nettype wire
